// ### pkg/homing_fault_pkg.sv
package homing_fault_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] status_offset = 8'h04;
    localparam logic [7:0] mask_offset = 8'h08;
    localparam logic [7:0] error_offset = 8'h0C;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int ctrl_start_bit = 0;
    localparam int ctrl_abort_bit = 1;
    localparam int ctrl_dir_bit = 2;
    localparam int ctrl_method_lsb = 3;
    localparam int ctrl_plim_en_bit = 5;
    localparam int ctrl_nlim_en_bit = 6;
    localparam int ctrl_reversal_bit = 7;
    localparam int ctrl_port_out_bit = 8;
    localparam int ctrl_gear_start_bit = 9;
    localparam int ctrl_moving_bit = 10;
    localparam int ctrl_width = 11;

    // ----------------------------------------
    // Status / interrupt bits
    // ----------------------------------------
    localparam int irq_homing_bit = 0;
    localparam int irq_gear_bit = 1;
    localparam int irq_done_bit = 2;
    localparam int irq_width = 3;

    localparam int state_busy_bit = 8;
    localparam int state_ref_ok_bit = 9;

    // ----------------------------------------
    // Error report
    // ----------------------------------------
    localparam logic [15:0] err_general = 16'hA324;
    localparam logic [15:0] err_lim_disabled = 16'hA325;
    localparam logic [15:0] err_ref_not_found = 16'hA326;
    localparam logic [15:0] err_lim_in_search = 16'hA327;
    localparam logic [15:0] err_overtravel = 16'hA328;
    localparam logic [15:0] err_multi_active = 16'hA329;
    localparam logic [15:0] err_plim_wrong_dir = 16'hA32A;
    localparam logic [15:0] err_nlim_wrong_dir = 16'hA32B;
    localparam logic [15:0] err_ref_brief = 16'hA32C;
    localparam logic [15:0] err_plim_brief = 16'hA32D;
    localparam logic [15:0] err_gear_port = 16'hA321;
    localparam logic [3:0] err_class = 4'h1;
    localparam logic [4:0] err_status_bit = 5'h0A;

    // ----------------------------------------
    // Homing methods and states
    // ----------------------------------------
    typedef enum logic [1:0] {
        method_plim = 2'b00,
        method_nlim = 2'b01,
        method_ref = 2'b10
    } method_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_search = 2'b01,
        st_hold = 2'b10
    } state_t;

    // Time a switch must stay active after stop in reference and positive limit homing
    localparam int settle_ns = 1000;
    localparam int clk_period_ns = 25;
    localparam int settle_cycles = (settle_ns + clk_period_ns - 1) / clk_period_ns;

endpackage

// ### rtl/homing_fault_detector.sv
`timescale 1ns/1ps
`default_nettype none
module homing_fault_detector (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Switch pins
    input wire logic positive_limit_switch,
    input wire logic negative_limit_switch,
    input wire logic reference_switch,
    // Motion side
    output logic homing_active,
    output logic homing_abort,
    output logic ref_ok,
    output logic irq
);
    logic [2:0] sw;
    logic plim;
    logic nlim;
    logic refsw;
    logic [homing_fault_pkg::ctrl_width-1:0] ctrl;
    logic [homing_fault_pkg::irq_width-1:0] status;
    logic [homing_fault_pkg::irq_width-1:0] mask;
    logic [15:0] sub_code;
    logic [15:0] main_code;
    homing_fault_pkg::state_t state;
    logic [1:0] prev_sw;
    logic seen_plim;
    logic seen_nlim;
    logic [7:0] settle_cnt;
    logic fault;
    logic [15:0] fault_code;
    logic gear_fault;
    logic done;
    logic wr;
    logic rd;
    logic [2:0] multi;
    logic dir_pos;
    logic reversal;
    logic [1:0] method;
    logic move_pos;
    logic fault_flag;

    switch_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .enable(clk_en),
        .pin_in({reference_switch, negative_limit_switch, positive_limit_switch}),
        .pin_sync(sw)
    );

    assign plim = sw[0];
    assign nlim = sw[1];
    assign refsw = sw[2];
    assign dir_pos = ctrl[homing_fault_pkg::ctrl_dir_bit];
    assign reversal = ctrl[homing_fault_pkg::ctrl_reversal_bit];
    assign method = ctrl[homing_fault_pkg::ctrl_method_lsb +: 2];
    assign multi = {refsw, nlim, plim};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------
    // Switch decode
    // ----------------------------------------
    function automatic logic several(input logic [2:0] s);
        several = (s[0] && s[1]) || (s[0] && s[2]) || (s[1] && s[2]);
    endfunction

    // ----------------------------------------
    // Direction of travel
    // ----------------------------------------
    // In reference homing with reversal the axis turns once it has left the search-side limit
    assign move_pos = (method == homing_fault_pkg::method_ref && reversal)
                      ? (dir_pos ? !(seen_plim && !plim) : (seen_nlim && !nlim))
                      : dir_pos;

    // ----------------------------------------
    // APB access
    // ----------------------------------------
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel && penable && pwrite && clk_en;
    assign rd = psel && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else if (clk_en) begin
            if (wr && hit(paddr, homing_fault_pkg::ctrl_offset)) begin
                ctrl <= pwdata[homing_fault_pkg::ctrl_width-1:0];
            end else begin
                ctrl[homing_fault_pkg::ctrl_start_bit] <= 1'b0;
                ctrl[homing_fault_pkg::ctrl_abort_bit] <= 1'b0;
                ctrl[homing_fault_pkg::ctrl_gear_start_bit] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= '0;
        end else if (clk_en && wr && hit(paddr, homing_fault_pkg::mask_offset)) begin
            mask <= pwdata[homing_fault_pkg::irq_width-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (clk_en && rd) begin
            prdata <= 32'h0;
            if (hit(paddr, homing_fault_pkg::ctrl_offset)) begin
                prdata[homing_fault_pkg::ctrl_width-1:0] <= ctrl;
            end else if (hit(paddr, homing_fault_pkg::status_offset)) begin
                prdata[homing_fault_pkg::irq_width-1:0] <= status;
                prdata[homing_fault_pkg::state_busy_bit] <= homing_active;
                prdata[homing_fault_pkg::state_ref_ok_bit] <= ref_ok;
            end else if (hit(paddr, homing_fault_pkg::mask_offset)) begin
                prdata[homing_fault_pkg::irq_width-1:0] <= mask;
            end else if (hit(paddr, homing_fault_pkg::error_offset)) begin
                prdata <= {sub_code, main_code};
            end
        end
    end

    // ----------------------------------------
    // Fault detection
    // ----------------------------------------
    always_comb begin
        fault = 1'b0;
        fault_code = homing_fault_pkg::err_general;
        if (state == homing_fault_pkg::st_search) begin
            if (several(multi)) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_multi_active;
            end else if (plim && !move_pos) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_plim_wrong_dir;
            end else if (nlim && move_pos) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_nlim_wrong_dir;
            end else if (method == homing_fault_pkg::method_ref && !reversal
                         && ((dir_pos && plim) || (!dir_pos && nlim))) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_lim_in_search;
            end else if (method == homing_fault_pkg::method_ref && !reversal
                         && prev_sw[1] && !refsw) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_overtravel;
            end else if (method == homing_fault_pkg::method_ref && reversal
                         && seen_plim && seen_nlim) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_ref_not_found;
            end
        end else if (state == homing_fault_pkg::st_hold) begin
            if (several(multi)) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_multi_active;
            end else if (method == homing_fault_pkg::method_ref && !refsw) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_ref_brief;
            end else if (method == homing_fault_pkg::method_plim && !plim) begin
                fault = 1'b1;
                fault_code = homing_fault_pkg::err_plim_brief;
            end
        end
    end

    assign gear_fault = ctrl[homing_fault_pkg::ctrl_gear_start_bit]
                        && ctrl[homing_fault_pkg::ctrl_port_out_bit];

    // ----------------------------------------
    // Homing sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= homing_fault_pkg::st_idle;
            homing_abort <= 1'b0;
            ref_ok <= 1'b0;
            done <= 1'b0;
            fault_flag <= 1'b0;
            settle_cnt <= 8'h00;
            sub_code <= 16'h0000;
            main_code <= 16'h0000;
            prev_sw <= 2'h0;
            seen_plim <= 1'b0;
            seen_nlim <= 1'b0;
        end else if (clk_en) begin
            homing_abort <= 1'b0;
            done <= 1'b0;
            fault_flag <= 1'b0;
            prev_sw <= {refsw, 1'b0};
            if (gear_fault) begin
                main_code <= homing_fault_pkg::err_gear_port;
            end
            case (state)
                homing_fault_pkg::st_idle: begin
                    if (ctrl[homing_fault_pkg::ctrl_start_bit]) begin
                        ref_ok <= 1'b0;
                        seen_plim <= 1'b0;
                        seen_nlim <= 1'b0;
                        if ((method == homing_fault_pkg::method_plim
                             && !ctrl[homing_fault_pkg::ctrl_plim_en_bit])
                            || (method == homing_fault_pkg::method_nlim
                             && !ctrl[homing_fault_pkg::ctrl_nlim_en_bit])) begin
                            main_code <= homing_fault_pkg::err_general;
                            sub_code <= homing_fault_pkg::err_lim_disabled;
                            fault_flag <= 1'b1;
                            homing_abort <= 1'b1;
                        end else begin
                            state <= homing_fault_pkg::st_search;
                        end
                    end
                end
                homing_fault_pkg::st_search: begin
                    if (plim) begin
                        seen_plim <= 1'b1;
                    end
                    if (nlim) begin
                        seen_nlim <= 1'b1;
                    end
                    if (fault || ctrl[homing_fault_pkg::ctrl_abort_bit]) begin
                        if (fault) begin
                            main_code <= homing_fault_pkg::err_general;
                            sub_code <= fault_code;
                            fault_flag <= 1'b1;
                        end
                        homing_abort <= 1'b1;
                        state <= homing_fault_pkg::st_idle;
                    end else if (!ctrl[homing_fault_pkg::ctrl_moving_bit]
                                 && ((method == homing_fault_pkg::method_plim && plim)
                                  || (method == homing_fault_pkg::method_nlim && nlim)
                                  || (method == homing_fault_pkg::method_ref && refsw))) begin
                        settle_cnt <= 8'h00;
                        state <= homing_fault_pkg::st_hold;
                    end
                end
                homing_fault_pkg::st_hold: begin
                    if (fault || ctrl[homing_fault_pkg::ctrl_abort_bit]) begin
                        if (fault) begin
                            main_code <= homing_fault_pkg::err_general;
                            sub_code <= fault_code;
                            fault_flag <= 1'b1;
                        end
                        homing_abort <= 1'b1;
                        state <= homing_fault_pkg::st_idle;
                    end else if (settle_cnt == 8'(homing_fault_pkg::settle_cycles - 1)) begin
                        ref_ok <= 1'b1;
                        done <= 1'b1;
                        state <= homing_fault_pkg::st_idle;
                    end else begin
                        settle_cnt <= settle_cnt + 8'h01;
                    end
                end
                default: begin
                    state <= homing_fault_pkg::st_idle;
                end
            endcase
        end
    end

    assign homing_active = (state != homing_fault_pkg::st_idle);

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else if (clk_en) begin
            if (wr && hit(paddr, homing_fault_pkg::status_offset)) begin
                status <= (status & ~pwdata[homing_fault_pkg::irq_width-1:0])
                          | {done, gear_fault, fault_flag};
            end else begin
                status <= status | {done, gear_fault, fault_flag};
            end
        end
    end

    assign irq = |(status & mask);
endmodule
`default_nettype wire

// ### rtl/switch_sync.sv
`timescale 1ns/1ps
`default_nettype none
module switch_sync (
    // Clock
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    // Pins
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_sync
);
    logic [2:0] meta;

    // ----------------------------------------
    // Two stage synchroniser
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 3'h0;
            pin_sync <= 3'h0;
        end else if (enable) begin
            meta <= pin_in;
            pin_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ### tb/axis_switches.sv
`timescale 1ns/1ps
`default_nettype none
module axis_switches (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Axis position as switch levels: bit 0 positive, 1 negative, 2 reference
    input wire logic [2:0] level,
    // Switch pins
    output logic positive_limit_switch,
    output logic negative_limit_switch,
    output logic reference_switch
);
    // Pins follow the axis after the edge, all open at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {reference_switch, negative_limit_switch, positive_limit_switch} <= 3'h0;
        end else begin
            {reference_switch, negative_limit_switch, positive_limit_switch} <= level;
        end
    end
endmodule
`default_nettype wire

// ### tb/homing_fault_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module homing_fault_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Switches and motion
    input wire logic positive_limit_switch,
    input wire logic negative_limit_switch,
    input wire logic reference_switch,
    input wire logic homing_active,
    input wire logic homing_abort,
    input wire logic ref_ok
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic multi;
    assign multi = (positive_limit_switch & negative_limit_switch)
        | ((positive_limit_switch | negative_limit_switch) & reference_switch);
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_no_slverr: assert property (!pslverr)
        else $error("pslverr high");
    a_abort_one_cycle: assert property (homing_abort |=> !homing_abort)
        else $error("abort pulse too long");
    a_abort_ends_run: assert property (homing_abort |-> ##[0:1] !homing_active)
        else $error("run goes on after abort");
    a_abort_clears_ref: assert property (homing_abort |-> ##[0:2] !ref_ok)
        else $error("reference kept after abort");
    a_ref_after_run: assert property ($rose(ref_ok) |-> $past(homing_active))
        else $error("reference set without run");
    a_run_end_reason: assert property ($fell(homing_active) |-> ##[0:1] (homing_abort || ref_ok))
        else $error("run ended without reason");
    a_multi_pin_abort: assert property ((homing_active && multi) [*2] |-> ##[0:5] homing_abort)
        else $error("several switches not flagged");
    a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr >= 8'h10
        |=> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind homing_fault_detector homing_fault_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .positive_limit_switch(positive_limit_switch),
    .negative_limit_switch(negative_limit_switch), .reference_switch(reference_switch),
    .homing_active(homing_active), .homing_abort(homing_abort), .ref_ok(ref_ok));
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, plim, nlim, refs, active, abort_p, ref_ok, irq;
    logic [2:0] level = 3'h0;
    logic [2:0] msk;
    logic [7:0] ua;
    logic [31:0] lfsr = 32'hD0501422;
    logic [31:0] rd;
    int mismatches = 0;
    int check_count = 0;
    int aborts = 0;
    int cycles = 0;
    int a_base = 0;

    always #12.5 pclk = ~pclk;

    homing_fault_detector dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .positive_limit_switch(plim),
        .negative_limit_switch(nlim), .reference_switch(refs), .homing_active(active),
        .homing_abort(abort_p), .ref_ok(ref_ok), .irq(irq));
    axis_switches axis (.pclk(pclk), .presetn(presetn), .level(level),
        .positive_limit_switch(plim), .negative_limit_switch(nlim), .reference_switch(refs));

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] err_word(input logic [15:0] sub);
        return {sub, 16'hA324};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic home(input logic [10:0] ctrl, input logic [2:0] p1, input logic [2:0] p2,
        input logic [15:0] sub);
        int a0;
        logic [31:0] st;
        lfsr = lfsr_next(lfsr);
        msk = lfsr[2:0];
        apb(1'b1, 8'h08, {29'h0, msk});
        a0 = aborts;
        apb(1'b1, 8'h00, {21'h0, ctrl});
        repeat (4) @(posedge pclk);
        level <= p1;
        repeat (8) @(posedge pclk);
        level <= p2;
        repeat (50) @(posedge pclk);
        st = (sub == 16'h0) ? 32'h204 : 32'h1;
        if (sub != 16'h0) begin
            apb(1'b0, 8'h0C, 32'h0);
            chk(rd, err_word(sub));
        end
        chk(32'(aborts - a0), {31'h0, sub != 16'h0});
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h207, st);
        chk({31'h0, irq}, {31'h0, |(st[2:0] & msk)});
        level <= 3'h0;
        apb(1'b1, 8'h04, 32'h7);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        $display("test ctrl=%h over", ctrl);
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (abort_p === 1'b1) begin
            aborts <= aborts + 1;
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    // ----
    // Sequence
    // ----
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk({28'h0, active, abort_p, ref_ok, irq}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            ua = 8'h10 | (lfsr[7:0] & 8'hFC);
            apb(1'b1, ua, lfsr);
            apb(1'b0, ua, 32'h0);
            chk(rd, 32'h0);
        end
        $display("test registers over");
        home(11'h401, 3'h0, 3'h0, 16'hA325);
        home(11'h409, 3'h0, 3'h0, 16'hA325);
        home(11'h415, 3'h5, 3'h5, 16'hA329);
        home(11'h449, 3'h1, 3'h1, 16'hA32A);
        home(11'h425, 3'h2, 3'h2, 16'hA32B);
        home(11'h415, 3'h1, 3'h1, 16'hA327);
        home(11'h415, 3'h4, 3'h0, 16'hA328);
        home(11'h495, 3'h1, 3'h2, 16'hA326);
        home(11'h015, 3'h4, 3'h0, 16'hA32C);
        home(11'h025, 3'h1, 3'h0, 16'hA32D);
        home(11'h015, 3'h4, 3'h4, 16'h0000);
        home(11'h401, 3'h0, 3'h0, 16'hA325);
        apb(1'b1, 8'h00, 32'h415);
        a_base = aborts;
        apb(1'b1, 8'h00, 32'h402);
        repeat (3) @(posedge pclk);
        chk(32'(aborts - a_base), 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h301, 32'h0);
        $display("test user abort over");
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h00, (i == 1) ? 32'h300 : 32'h200);
            apb(1'b0, 8'h04, 32'h0);
            chk(rd & 32'h2, (i == 1) ? 32'h2 : 32'h0);
        end
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'hFFFF, 32'hA321);
        apb(1'b1, 8'h04, 32'h7);
        $display("test gear over");
        summarize();
    end
endmodule
`default_nettype wire
